// File: mtgp_port.sv
// Design decision made here: register access over AXI4-Lite.
`include "mtgp_params.svh"
`default_nettype none
module mtgp_port (
	input wire logic CORE_CLK, // Bus clock
	input wire logic RST, // Async reset, high
	input wire logic [15:0] S_AXI_AWADDR, // Write address
	input wire logic S_AXI_AWVALID, // Write address valid
	output logic S_AXI_AWREADY, // Write address ready
	input wire logic [31:0] S_AXI_WDATA, // Write data
	input wire logic [3:0] S_AXI_WSTRB, // Byte enables
	input wire logic S_AXI_WVALID, // Write data valid
	output logic S_AXI_WREADY, // Write data ready
	output logic [1:0] S_AXI_BRESP, // Write response
	output logic S_AXI_BVALID, // Write response valid
	input wire logic S_AXI_BREADY, // Write response ready
	input wire logic [15:0] S_AXI_ARADDR, // Read address
	input wire logic S_AXI_ARVALID, // Read address valid
	output logic S_AXI_ARREADY, // Read address ready
	output logic [31:0] S_AXI_RDATA, // Read data
	output logic [1:0] S_AXI_RRESP, // Read response
	output logic S_AXI_RVALID, // Read data valid
	input wire logic S_AXI_RREADY, // Read data ready
	input wire logic [7:0] PIN_IN, // Pad input levels
	output logic [7:0] PIN_OUT, // Pad output values
	output logic [7:0] PIN_OE_N, // Pad drive enable, low
	output logic [7:0] PULL_UP_EN, // Pull-up device on
	output logic [7:0] PULL_DN_EN, // Pull-down device on
	input wire logic [7:0] MOTOR_PWM_EN, // Motor PWM enabled
	input wire logic [7:0] MOTOR_PWM_OUT, // Motor PWM levels
	input wire logic [3:0] TIMER_OC_EN, // Timer outputs enabled
	input wire logic [3:0] TIMER_OC_OUT // Timer output levels
);

	// Address to register decode, shared by both channels
	function automatic mtgp_pkg::mtgp_reg_t reg_of(
		input logic [15:0] addr);
		logic [13:0] idx;
		idx = addr[15:2];
		case (idx)
			`MTGP_IDX_DATA: reg_of = mtgp_pkg::MTGP_R_DATA;
			`MTGP_IDX_LEVEL: reg_of = mtgp_pkg::MTGP_R_LEVEL;
			`MTGP_IDX_DIR: reg_of = mtgp_pkg::MTGP_R_DIR;
			`MTGP_IDX_RSVD_A: reg_of = mtgp_pkg::MTGP_R_RSVD;
			`MTGP_IDX_RSVD_B: reg_of = mtgp_pkg::MTGP_R_RSVD;
			`MTGP_IDX_PULL: reg_of = mtgp_pkg::MTGP_R_PULL;
			`MTGP_IDX_POL: reg_of = mtgp_pkg::MTGP_R_POL;
			default: reg_of = mtgp_pkg::MTGP_R_NONE;
		endcase
	endfunction

	logic [7:0] data_ff;
	logic [7:0] dir_ff;
	logic [7:0] pull_ff;
	logic [7:0] pol_ff;
	logic [7:0] sync_a_ff;
	logic [7:0] pin_lvl_ff;
	logic aw_held_ff;
	logic w_held_ff;
	logic [15:0] awaddr_ff;
	logic [7:0] wbyte_ff;
	logic wstrb_ff;
	logic bvalid_ff;
	logic [1:0] bresp_ff;
	logic rvalid_ff;
	logic [1:0] rresp_ff;
	logic [7:0] rbyte_ff;
	logic [7:0] pin_out_ff;
	logic [7:0] oe_n_ff;
	logic [7:0] pull_up_ff;
	logic [7:0] pull_dn_ff;

	// Write channel decode
	wire logic wr_fire;
	wire mtgp_pkg::mtgp_reg_t wr_reg;
	wire logic wr_lane;
	wire logic wr_data;
	wire logic wr_dir;
	wire logic wr_pull;
	wire logic wr_pol;
	assign wr_fire = aw_held_ff & w_held_ff & ~bvalid_ff;
	assign wr_reg = reg_of(awaddr_ff);
	assign wr_lane = wr_fire & wstrb_ff;
	assign wr_data = wr_lane & (wr_reg == mtgp_pkg::MTGP_R_DATA); // [R15]
	assign wr_dir = wr_lane & (wr_reg == mtgp_pkg::MTGP_R_DIR);
	assign wr_pull = wr_lane & (wr_reg == mtgp_pkg::MTGP_R_PULL);
	assign wr_pol = wr_lane & (wr_reg == mtgp_pkg::MTGP_R_POL);

	// Read channel decode; level and reserved take no write path
	wire logic rd_fire;
	wire mtgp_pkg::mtgp_reg_t rd_reg;
	logic [7:0] rd_val;
	assign rd_fire = S_AXI_ARVALID & ~rvalid_ff;
	assign rd_reg = reg_of(S_AXI_ARADDR);
	// Data read picks stored bit or pin level per direction
	wire logic [7:0] rd_port;
	assign rd_port = (dir_ff & data_ff) | (~dir_ff & pin_lvl_ff); // [R1]
	always_comb begin
		case (rd_reg)
			mtgp_pkg::MTGP_R_DATA: rd_val = rd_port; // [R1]
			mtgp_pkg::MTGP_R_LEVEL: rd_val = pin_lvl_ff; // [R6]
			mtgp_pkg::MTGP_R_DIR: rd_val = dir_ff;
			mtgp_pkg::MTGP_R_PULL: rd_val = pull_ff;
			mtgp_pkg::MTGP_R_POL: rd_val = pol_ff;
			default: rd_val = 8'h00; // [R14]
		endcase
	end

	// Bus handshakes
	assign S_AXI_AWREADY = ~aw_held_ff;
	assign S_AXI_WREADY = ~w_held_ff;
	assign S_AXI_BVALID = bvalid_ff;
	assign S_AXI_BRESP = bresp_ff;
	assign S_AXI_ARREADY = ~rvalid_ff;
	assign S_AXI_RVALID = rvalid_ff;
	assign S_AXI_RRESP = rresp_ff;
	assign S_AXI_RDATA = {24'h00_0000, rbyte_ff};

	// Hold write address and data until both are in
	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			aw_held_ff <= 1'b0;
			awaddr_ff <= 16'h0000;
		end else if (S_AXI_AWVALID & ~aw_held_ff) begin
			aw_held_ff <= 1'b1;
			awaddr_ff <= S_AXI_AWADDR;
		end else if (wr_fire) begin
			aw_held_ff <= 1'b0;
		end
	end

	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			w_held_ff <= 1'b0;
			wbyte_ff <= 8'h00;
			wstrb_ff <= 1'b0;
		end else if (S_AXI_WVALID & ~w_held_ff) begin
			w_held_ff <= 1'b1;
			wbyte_ff <= S_AXI_WDATA[`MTGP_FLD_MSB:`MTGP_FLD_LSB];
			wstrb_ff <= S_AXI_WSTRB[0];
		end else if (wr_fire) begin
			w_held_ff <= 1'b0;
		end
	end

	// Write response; unmapped addresses answer SLVERR
	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			bvalid_ff <= 1'b0;
			bresp_ff <= `MTGP_RESP_OKAY;
		end else if (wr_fire) begin
			bvalid_ff <= 1'b1;
			bresp_ff <= (wr_reg == mtgp_pkg::MTGP_R_NONE) ?
				`MTGP_RESP_SLVERR : `MTGP_RESP_OKAY;
		end else if (S_AXI_BREADY) begin
			bvalid_ff <= 1'b0;
		end
	end

	// Read response, data captured when the address is taken
	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			rvalid_ff <= 1'b0;
			rresp_ff <= `MTGP_RESP_OKAY;
			rbyte_ff <= 8'h00;
		end else if (rd_fire) begin
			rvalid_ff <= 1'b1;
			rbyte_ff <= rd_val;
			rresp_ff <= (rd_reg == mtgp_pkg::MTGP_R_NONE) ?
				`MTGP_RESP_SLVERR : `MTGP_RESP_OKAY;
		end else if (S_AXI_RREADY) begin
			rvalid_ff <= 1'b0;
		end
	end

	// Software registers; level and reserved writes go nowhere
	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			data_ff <= `MTGP_RST_DATA; // [R15]
			dir_ff <= `MTGP_RST_DIR;
			pull_ff <= `MTGP_RST_PULL; // [R13]
			pol_ff <= `MTGP_RST_POL;
		end else begin
			if (wr_data) data_ff <= wbyte_ff; // [R15]
			if (wr_dir) dir_ff <= wbyte_ff; // [R10]
			if (wr_pull) pull_ff <= wbyte_ff;
			if (wr_pol) pol_ff <= wbyte_ff;
		end
	end

	// Two-stage pin input buffer, the latency software waits out
	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			sync_a_ff <= 8'h00;
			pin_lvl_ff <= 8'h00;
		end else begin
			sync_a_ff <= PIN_IN; // [R11]
			pin_lvl_ff <= sync_a_ff; // [R6] [R7]
		end
	end

	// Per-pin owner select: motor, then timer, then register
	mtgp_pkg::mtgp_fn_t pin_fn [8];
	logic [7:0] nxt_pin_out;
	logic [7:0] nxt_drive;
	for (genvar i = 0; i < 8; i++) begin : g_pin
		wire logic tim_en;
		wire logic tim_val;
		assign tim_en = ((i % 2) == 0) ? TIMER_OC_EN[i / 2] : 1'b0;
		assign tim_val = TIMER_OC_OUT[i / 2];
		assign pin_fn[i] = MOTOR_PWM_EN[i] ? mtgp_pkg::MTGP_FN_MOTOR :
			tim_en ? mtgp_pkg::MTGP_FN_TIMER :
			mtgp_pkg::MTGP_FN_GPIO; // [R2] [R3] [R4] [R17]
		always_comb begin
			case (pin_fn[i])
				mtgp_pkg::MTGP_FN_MOTOR: begin
					nxt_pin_out[i] = MOTOR_PWM_OUT[i]; // [R2] [R3]
					nxt_drive[i] = 1'b1; // [R8]
				end
				mtgp_pkg::MTGP_FN_TIMER: begin
					nxt_pin_out[i] = tim_val; // [R4]
					nxt_drive[i] = 1'b1; // [R9]
				end
				default: begin
					nxt_pin_out[i] = data_ff[i];
					nxt_drive[i] = dir_ff[i]; // [R10]
				end
			endcase
		end
	end

	// Pull devices only on input pins, polarity picks direction
	wire logic [7:0] pull_act;
	wire logic [7:0] nxt_pull_up;
	wire logic [7:0] nxt_pull_dn;
	assign pull_act = pull_ff & ~nxt_drive; // [R12]
	assign nxt_pull_up = pull_act & ~pol_ff; // [R16]
	assign nxt_pull_dn = pull_act & pol_ff; // [R16]

	// Registered pad controls
	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			pin_out_ff <= 8'h00;
			oe_n_ff <= `MTGP_RST_OE_N;
			pull_up_ff <= 8'h00;
			pull_dn_ff <= 8'h00;
		end else begin
			pin_out_ff <= nxt_pin_out; // [R17]
			oe_n_ff <= ~nxt_drive;
			pull_up_ff <= nxt_pull_up;
			pull_dn_ff <= nxt_pull_dn;
		end
	end
	assign PIN_OUT = pin_out_ff;
	assign PIN_OE_N = oe_n_ff;
	assign PULL_UP_EN = pull_up_ff;
	assign PULL_DN_EN = pull_dn_ff;

	// Checks on pad muxing
	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (RST);

	a_motor_pin_out: assert property ( // [R2]
		!RST |=> ((PIN_OUT ^ $past(MOTOR_PWM_OUT))
			& $past(MOTOR_PWM_EN)) == 8'h00)
		else $error("Motor PWM level not on pin");
	a_motor_forces_out: assert property ( // [R8]
		!RST |=> (PIN_OE_N & $past(MOTOR_PWM_EN)) == 8'h00)
		else $error("Motor PWM pin not driven");
	a_motor_over_timer: assert property ( // [R3]
		MOTOR_PWM_EN[0] && TIMER_OC_EN[0]
		|=> PIN_OUT[0] == $past(MOTOR_PWM_OUT[0]))
		else $error("Timer beat motor on pin 0");
	a_timer_pin_out: assert property ( // [R4]
		TIMER_OC_EN[0] && !MOTOR_PWM_EN[0]
		|=> PIN_OUT[0] == $past(TIMER_OC_OUT[0]))
		else $error("Timer level not on pin 0");
	a_timer_forces_out: assert property ( // [R9]
		TIMER_OC_EN[3] && !MOTOR_PWM_EN[6] |=> !PIN_OE_N[6])
		else $error("Timer pin 6 not driven");
	a_dir_sets_oe: assert property ( // [R10]
		!MOTOR_PWM_EN[1] |=> PIN_OE_N[1] == !$past(dir_ff[1]))
		else $error("Direction bit not on pin 1");
	a_gpio_pin_out: assert property ( // [R17]
		!MOTOR_PWM_EN[5] |=> PIN_OUT[5] == $past(data_ff[5]))
		else $error("Data bit not on pin 5");
	a_pull_inputs_only: assert property ( // [R12]
		((PULL_UP_EN | PULL_DN_EN) & ~PIN_OE_N) == 8'h00)
		else $error("Pull active on output pin");
	a_pull_polarity: assert property ( // [R16]
		(PULL_UP_EN & pol_ff) == 8'h00 && (PULL_DN_EN & ~pol_ff)
		== 8'h00 || $changed(pol_ff))
		else $error("Pull polarity wrong");

	// Checks on register access
	a_level_read_pins: assert property ( // [R6]
		rd_fire && rd_reg == mtgp_pkg::MTGP_R_LEVEL
		|=> S_AXI_RVALID && S_AXI_RDATA[7:0] == $past(pin_lvl_ff))
		else $error("Level read not pin state");
	a_data_read_mux: assert property ( // [R1]
		rd_fire && rd_reg == mtgp_pkg::MTGP_R_DATA
		|=> S_AXI_RDATA[7:0] == $past((dir_ff & data_ff)
			| (~dir_ff & pin_lvl_ff)))
		else $error("Data read mux wrong");
	a_level_write_void: assert property ( // [R7]
		wr_fire && wr_reg == mtgp_pkg::MTGP_R_LEVEL
		|=> $stable(data_ff) && $stable(dir_ff) && $stable(pull_ff)
			&& $stable(pol_ff))
		else $error("Level write changed state");
	a_rsvd_read_zero: assert property ( // [R14]
		rd_fire && rd_reg == mtgp_pkg::MTGP_R_RSVD
		|=> S_AXI_RDATA == 32'h0000_0000
			&& S_AXI_RRESP == `MTGP_RESP_OKAY)
		else $error("Reserved read not zero");
	a_data_write: assert property ( // [R15]
		wr_fire && wr_reg == mtgp_pkg::MTGP_R_DATA && wstrb_ff
		|=> data_ff == $past(wbyte_ff) && S_AXI_BVALID)
		else $error("Data write lost");
	a_pin_level_lag: assert property ( // [R11]
		!RST |=> ##1 pin_lvl_ff == $past(PIN_IN, 2))
		else $error("Pin level lag not two");
	a_reset_clears: assert property ( // [R13]
		@(posedge CORE_CLK) $past(RST) |-> pull_ff == 8'h00
			&& data_ff == 8'h00)
		else $error("Reset left pull or data set");

	c_motor_owns: cover property (MOTOR_PWM_EN[7] ##1 !PIN_OE_N[7]);
	c_timer_owns: cover property (TIMER_OC_EN[2] && !MOTOR_PWM_EN[4]);
	c_write_done: cover property (wr_data ##1 S_AXI_BVALID);
	c_read_level: cover property (rd_fire
		&& rd_reg == mtgp_pkg::MTGP_R_LEVEL);

endmodule
`default_nettype wire

// File: mtgp_params.svh
// Contract
// [R1] Data read: direction set gives register, else pin
// [R2] Odd pins: motor PWM overrides plain I/O
// [R3] Even pins: motor PWM overrides timer and I/O
// [R4] Even pins: enabled timer output overrides plain I/O
// [R5] Software clears outputs and slew before capture
// [R6] Level register always returns buffered pin state
// [R7] Writes to level register change nothing
// [R8] Motor PWM forces pin to output
// [R9] Even pins: timer output forces pin to output
// [R10] Direction bit one is output, zero input
// [R11] Direction change shows after two clocks
// [R12] Pull device only acts on input pins
// [R13] Reset clears every pull enable
// [R14] Reserved locations read zero, ignore writes
// [R15] Data register always accessible, resets zero
// [R16] Polarity zero pulls up, one pulls down
// [R17] Per-pin priority mux: motor, timer, data
`ifndef MTGP_PARAMS_SVH
`define MTGP_PARAMS_SVH

// Register indices; byte address is four times the index
`define MTGP_IDX_DATA 14'h0290
`define MTGP_IDX_LEVEL 14'h0291
`define MTGP_IDX_DIR 14'h0292
`define MTGP_IDX_RSVD_A 14'h0293
`define MTGP_IDX_PULL 14'h0294
`define MTGP_IDX_POL 14'h0295
`define MTGP_IDX_RSVD_B 14'h0297

// Field layout: every register sits in the low byte
`define MTGP_FLD_LSB 0
`define MTGP_FLD_MSB 7

// Reset values
`define MTGP_RST_DATA 8'h00
`define MTGP_RST_DIR 8'h00
`define MTGP_RST_PULL 8'h00
`define MTGP_RST_POL 8'h00
`define MTGP_RST_OE_N 8'hFF

// Bus answers
`define MTGP_RESP_OKAY 2'h0
`define MTGP_RESP_SLVERR 2'h2

`endif

// File: mtgp_pkg.sv
`default_nettype none
package mtgp_pkg;

	// Register selected by an address
	typedef enum logic [2:0] {
		MTGP_R_NONE = 3'h0,
		MTGP_R_DATA = 3'h1,
		MTGP_R_LEVEL = 3'h3,
		MTGP_R_DIR = 3'h2,
		MTGP_R_RSVD = 3'h6,
		MTGP_R_PULL = 3'h7,
		MTGP_R_POL = 3'h5
	} mtgp_reg_t;

	// Owner of a pin, Gray coded by rising priority
	typedef enum logic [1:0] {
		MTGP_FN_GPIO = 2'h0,
		MTGP_FN_TIMER = 2'h1,
		MTGP_FN_MOTOR = 2'h3
	} mtgp_fn_t;

endpackage
`default_nettype wire

// File: mtgp_pad_model.sv
`default_nettype none
module mtgp_pad_model (
	input wire logic clk, // Bus clock
	input wire logic [7:0] pin_out, // Values the port drives
	input wire logic [7:0] pin_oe_n, // Port drive enable, low
	input wire logic [7:0] pull_up, // Pull-up devices on
	input wire logic [7:0] pull_dn, // Pull-down devices on
	input wire logic [7:0] ext_en, // Outside driver active
	input wire logic [7:0] ext_val, // Outside driver levels
	output logic [7:0] pin_in // Resolved pad levels
);
	logic [7:0] last_ff = 8'h00;

	// Pad level: port drive, outside drive, pull, else a floating toggle
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			if (!pin_oe_n[i])
				pin_in[i] = pin_out[i];
			else if (ext_en[i])
				pin_in[i] = ext_val[i];
			else if (pull_up[i])
				pin_in[i] = 1'b1;
			else if (pull_dn[i])
				pin_in[i] = 1'b0;
			else
				pin_in[i] = ~last_ff[i];
		end
	end

	// Remembers the last level so a floating pad never looks stable
	always_ff @(posedge clk) begin
		last_ff <= pin_in;
	end
endmodule
`default_nettype wire

// File: tb_top.sv
`include "mtgp_params.svh"
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk = 0, rst = 1;
	logic awv = 0, wv = 0, bready = 0, arv = 0, rready = 0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [15:0] awaddr = 16'h0000, araddr = 16'h0000;
	logic [31:0] wdata = 32'h0000_0000, rdata;
	logic [1:0] bresp, rresp;
	logic [7:0] pin_in, pin_out, oe_n, pu, pd;
	logic [7:0] m_en = 8'h00, m_out = 8'h00;
	logic [7:0] ext_en = 8'hFF, ext_val = 8'h00;
	logic [3:0] t_en = 4'h0, t_out = 4'h0, wstrb = 4'hF;
	int error_cnt = 0, cmp_count = 0, cyc = 0;

	always #2.5 clk = ~clk;

	mtgp_port mtgp_port_inst (.CORE_CLK(clk), .RST(rst),
		.S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awready),
		.S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wv),
		.S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
		.S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arv),
		.S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
		.S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .PIN_IN(pin_in),
		.PIN_OUT(pin_out), .PIN_OE_N(oe_n), .PULL_UP_EN(pu),
		.PULL_DN_EN(pd), .MOTOR_PWM_EN(m_en), .MOTOR_PWM_OUT(m_out),
		.TIMER_OC_EN(t_en), .TIMER_OC_OUT(t_out));

	mtgp_pad_model mtgp_pad_model_inst (.clk(clk), .pin_out(pin_out),
		.pin_oe_n(oe_n), .pull_up(pu), .pull_dn(pd), .ext_en(ext_en),
		.ext_val(ext_val), .pin_in(pin_in));

	task automatic chk(input string nm, input logic [31:0] seen, exp);
		cmp_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// Bus write: address and data together, wait for the response
	task automatic wr(input logic [13:0] idx, input logic [31:0] d,
		input logic [1:0] er);
		@(posedge clk);
		awaddr <= {idx, 2'b00};
		wdata <= d;
		awv <= 1'b1;
		wv <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clk);
			if (awv && awready) awv <= 1'b0;
			if (wv && wready) wv <= 1'b0;
		end while (!bvalid);
		bready <= 1'b0;
		chk("bresp", {30'h0, bresp}, {30'h0, er});
	endtask

	// Bus read and compare of data and response
	task automatic rd(input string nm, input logic [13:0] idx,
		input logic [7:0] exp, input logic [1:0] er);
		@(posedge clk);
		araddr <= {idx, 2'b00};
		arv <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge clk);
			if (arv && arready) arv <= 1'b0;
		end while (!rvalid);
		rready <= 1'b0;
		chk(nm, rdata, {24'h0, exp});
		chk("rresp", {30'h0, rresp}, {30'h0, er});
	endtask

	task automatic pads(input logic [7:0] oe, out);
		repeat (3) @(posedge clk);
		chk("oe_n", {24'h0, oe_n}, {24'h0, oe});
		chk("pin_out", {24'h0, pin_out}, {24'h0, out});
	endtask

	// Values out of reset; pads held low from outside
	task automatic t_reset();
		chk("pull_up", {24'h0, pu | pd}, 32'h0000_0000);
		chk("oe_n", {24'h0, oe_n}, 32'h0000_00FF);
		rd("data", `MTGP_IDX_DATA, 8'h00, `MTGP_RESP_OKAY);
		rd("pull", `MTGP_IDX_PULL, 8'h00, `MTGP_RESP_OKAY);
	endtask

	// Input pins read the pad, pulls follow polarity
	task automatic t_input();
		ext_en <= 8'hFF;
		ext_val <= 8'h3C;
		wr(`MTGP_IDX_PULL, 32'h0000_00FF, `MTGP_RESP_OKAY);
		wr(`MTGP_IDX_POL, 32'h0000_000F, `MTGP_RESP_OKAY);
		repeat (3) @(posedge clk);
		chk("pull_up", {24'h0, pu}, 32'h0000_00F0);
		chk("pull_dn", {24'h0, pd}, 32'h0000_000F);
		rd("data", `MTGP_IDX_DATA, 8'h3C, `MTGP_RESP_OKAY);
		rd("level", `MTGP_IDX_LEVEL, 8'h3C, `MTGP_RESP_OKAY);
	endtask

	// Outputs drive stored data, mixed direction, level is read only
	task automatic t_output();
		ext_en <= 8'h00;
		wr(`MTGP_IDX_DATA, 32'h0000_00A5, `MTGP_RESP_OKAY);
		wr(`MTGP_IDX_DIR, 32'h0000_00FF, `MTGP_RESP_OKAY);
		pads(8'h00, 8'hA5);
		chk("pull", {24'h0, pu | pd}, 32'h0000_0000);
		rd("level", `MTGP_IDX_LEVEL, 8'hA5, `MTGP_RESP_OKAY);
		wr(`MTGP_IDX_LEVEL, 32'h0000_005A, `MTGP_RESP_OKAY);
		rd("data", `MTGP_IDX_DATA, 8'hA5, `MTGP_RESP_OKAY);
		wr(`MTGP_IDX_DIR, 32'h0000_000F, `MTGP_RESP_OKAY);
		repeat (3) @(posedge clk);
		chk("pull_up", {24'h0, pu}, 32'h0000_00F0);
		rd("data", `MTGP_IDX_DATA, 8'hF5, `MTGP_RESP_OKAY);
	endtask

	// Priority of motor PWM over timer over plain I/O
	task automatic t_alt();
		wr(`MTGP_IDX_DIR, 32'h0000_0000, `MTGP_RESP_OKAY);
		wr(`MTGP_IDX_DATA, 32'h0000_0000, `MTGP_RESP_OKAY);
		m_en <= 8'h03;
		m_out <= 8'h02;
		t_en <= 4'hF;
		t_out <= 4'hF;
		pads(8'hA8, 8'h56);
		chk("pull_dn", {24'h0, pd & 8'h57}, 32'h0000_0000);
		m_en <= 8'h00;
		pads(8'hAA, 8'h55);
		m_en <= 8'hA0;
		m_out <= 8'h80;
		t_en <= 4'h0;
		pads(8'h5F, 8'h80);
		// Capture use: every output function off, pin 0 driven outside
		m_en <= 8'h00;
		ext_en <= 8'h01;
		ext_val <= 8'h01;
		pads(8'hFF, 8'h00);
		rd("capture", `MTGP_IDX_LEVEL, 8'hF1, `MTGP_RESP_OKAY);
	endtask

	// Strobe-less write ignored; mid-run reset clears pulls and data
	task automatic t_rerst();
		ext_en <= 8'hFF;
		ext_val <= 8'h00;
		wr(`MTGP_IDX_DIR, 32'h0000_00FF, `MTGP_RESP_OKAY);
		wr(`MTGP_IDX_DATA, 32'h0000_005A, `MTGP_RESP_OKAY);
		wstrb <= 4'h0;
		wr(`MTGP_IDX_DATA, 32'h0000_00FF, `MTGP_RESP_OKAY);
		wstrb <= 4'hF;
		rd("data", `MTGP_IDX_DATA, 8'h5A, `MTGP_RESP_OKAY);
		@(posedge clk);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		chk("pull", {24'h0, pu | pd}, 32'h0000_0000);
		rd("pull", `MTGP_IDX_PULL, 8'h00, `MTGP_RESP_OKAY);
		rd("dir", `MTGP_IDX_DIR, 8'h00, `MTGP_RESP_OKAY);
		wr(`MTGP_IDX_DIR, 32'h0000_00FF, `MTGP_RESP_OKAY);
		rd("data", `MTGP_IDX_DATA, 8'h00, `MTGP_RESP_OKAY);
	endtask

	// Reserved places read zero, unmapped ones are refused
	task automatic t_rsvd();
		wr(`MTGP_IDX_RSVD_A, 32'h0000_00FF, `MTGP_RESP_OKAY);
		rd("rsvd_a", `MTGP_IDX_RSVD_A, 8'h00, `MTGP_RESP_OKAY);
		rd("rsvd_b", `MTGP_IDX_RSVD_B, 8'h00, `MTGP_RESP_OKAY);
		wr(14'h0296, 32'h0000_00FF, `MTGP_RESP_SLVERR);
		rd("unmapped", 14'h0296, 8'h00, `MTGP_RESP_SLVERR);
	endtask

	task automatic stop_test();
		$display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// Cuts a hang short
	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			error_cnt++;
			stop_test();
		end
	end

	// Main sequence
	initial begin
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		t_reset();
		t_input();
		t_output();
		t_alt();
		t_rsvd();
		t_rerst();
		stop_test();
	end
endmodule
`default_nettype wire
